// >>> rtl/cdx_exec.sv
// Function
// - Complement op writes inverted file value, updates zero flag.
// - Decrement op writes file value minus one, updates zero flag.
// - Decrement-skip op writes file value minus one, flags untouched.
// - Zero result of decrement-skip squashes the prefetched instruction.
// - Destination bit 0 selects accumulator, 1 writes back file 0..31.
//
// Execute stage for complement, decrement and decrement-skip.
// Assumes file_rdata is the combinational read of file_raddr this cycle,
// and that instr_valid marks one instruction per cycle from fetch.
`timescale 1ns/1ps
`include "cdx_params.svh"
module cdx_exec #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 5
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  output logic [ADDR_W-1:0] file_raddr,
  input wire logic [DATA_W-1:0] file_rdata,
  output logic file_we,
  output logic [ADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] acc,
  output logic zero_flag,
  output logic squash_next,
  output logic op_hit
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic zf;
    logic we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic squash;
    logic hit;
  } cdx_state_t;

  cdx_state_t st_q;
  cdx_state_t st_d;
  cdx_pkg::cdx_op_t op;
  logic dest_file;
  logic [4:0] faddr;
  logic [DATA_W-1:0] res;
  logic live;

  cdx_decode u_dec (
    .instr(instr),
    .op(op),
    .dest_file(dest_file),
    .file_addr(faddr)
  );

  function automatic logic is_null(input logic [DATA_W-1:0] v);
    is_null = (v == '0);
  endfunction

  assign file_raddr = ADDR_W'(faddr);
  // A squashed slot executes as a no-operation.
  assign live = instr_valid && !st_q.squash;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    st_d.we = 1'h0;
    st_d.squash = 1'h0;
    st_d.hit = 1'h0;
    st_d.waddr = file_raddr;
    // The result is formed for every word; only a live hit commits it.
    if (op == cdx_pkg::CDX_OP_COMPL) begin
      res = ~file_rdata;
    end else begin
      res = file_rdata - DATA_W'(1);
    end
    st_d.wdata = res;
    if (live && op != cdx_pkg::CDX_OP_NONE) begin
      st_d.hit = 1'h1;
      if (dest_file == `CDX_DEST_FILE) begin
        st_d.we = 1'h1;
      end else begin
        st_d.acc = res;
      end
      if (op != cdx_pkg::CDX_OP_DECSZ) begin
        st_d.zf = is_null(res);
      end else begin
        st_d.squash = is_null(res);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.acc <= `CDX_ACC_RST;
      st_q.zf <= `CDX_ZF_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign acc = st_q.acc;
  assign zero_flag = st_q.zf;
  assign file_we = st_q.we;
  assign file_waddr = st_q.waddr;
  assign file_wdata = st_q.wdata;
  assign squash_next = st_q.squash;
  assign op_hit = st_q.hit;

  ////////////////////////////////////////////////////////////////////////
  // The data checks take the operands at the taking edge through $past and
  // look at the registered outputs one edge later.
  property p_compl_data;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_COMPL && dest_file)
      |=> (file_we && file_wdata == ~$past(file_rdata));
  endproperty
  a_compl_data: assert property (p_compl_data)
    else $error("complement result wrong");

  property p_dec_data;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_DEC)
      |=> (file_wdata == $past(file_rdata) - DATA_W'(1));
  endproperty
  a_dec_data: assert property (p_dec_data)
    else $error("decrement result wrong");

  property p_dec_zf;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_DEC)
      |=> (zero_flag == ($past(file_rdata) == DATA_W'(1)));
  endproperty
  a_dec_zf: assert property (p_dec_zf)
    else $error("decrement zero flag wrong");

  property p_decsz_data;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_DECSZ)
      |=> (file_wdata == $past(file_rdata) - DATA_W'(1));
  endproperty
  a_decsz_data: assert property (p_decsz_data)
    else $error("skip op result wrong");

  property p_decsz_flags;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_DECSZ) |=> $stable(zero_flag);
  endproperty
  a_decsz_flags: assert property (p_decsz_flags)
    else $error("skip op changed zero flag");

  property p_skip;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_DECSZ && file_rdata == DATA_W'(1))
      |=> squash_next ##1 !squash_next && !op_hit;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip did not squash next");

  property p_noskip;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_DECSZ && file_rdata != DATA_W'(1))
      |=> !squash_next;
  endproperty
  a_noskip: assert property (p_noskip)
    else $error("skip op squashed on nonzero result");

  // A squashed slot must not write the file and must leave acc and zero_flag as they were.
  property p_squash_quiet;
    @(posedge core_clk) disable iff (srst)
    squash_next
      |=> (!op_hit && !file_we && $stable(acc) && $stable(zero_flag));
  endproperty
  a_squash_quiet: assert property (p_squash_quiet)
    else $error("squashed slot changed state");

  property p_no_hit;
    @(posedge core_clk) disable iff (srst)
    !(live && op != cdx_pkg::CDX_OP_NONE)
      |=> (!op_hit && !file_we && !squash_next);
  endproperty
  a_no_hit: assert property (p_no_hit)
    else $error("ignored word produced outputs");

  property p_acc_dest;
    @(posedge core_clk) disable iff (srst)
    (live && op != cdx_pkg::CDX_OP_NONE && !dest_file)
      |=> (!file_we && acc == file_wdata);
  endproperty
  a_acc_dest: assert property (p_acc_dest)
    else $error("accumulator destination wrong");

  property p_file_dest;
    @(posedge core_clk) disable iff (srst)
    (live && op != cdx_pkg::CDX_OP_NONE && dest_file)
      |=> (file_we && op_hit && file_waddr == $past(file_raddr)
           && $stable(acc));
  endproperty
  a_file_dest: assert property (p_file_dest)
    else $error("file destination wrong");

  property p_zf_value;
    @(posedge core_clk) disable iff (srst)
    (live && op == cdx_pkg::CDX_OP_COMPL)
      |=> (zero_flag == (file_wdata == '0));
  endproperty
  a_zf_value: assert property (p_zf_value)
    else $error("zero flag mismatch");

  ////////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios.
  c_compl: cover property (@(posedge core_clk) disable iff (srst)
    live && op == cdx_pkg::CDX_OP_COMPL);
  c_dec_zero: cover property (@(posedge core_clk) disable iff (srst)
    live && op == cdx_pkg::CDX_OP_DEC && file_rdata == DATA_W'(1));
  c_skip: cover property (@(posedge core_clk) disable iff (srst)
    squash_next ##1 instr_valid);
  c_file_dest: cover property (@(posedge core_clk) disable iff (srst)
    live && op != cdx_pkg::CDX_OP_NONE && dest_file);
endmodule

// >>> rtl/cdx_params.svh
// Opcode patterns, field positions and reset values for the file-op unit.
// Assumes nothing; included by the package users by bare name.
`ifndef CDX_PARAMS_SVH
`define CDX_PARAMS_SVH
`define CDX_OPC_HI 11
`define CDX_OPC_LO 6
`define CDX_OPC_COMPL 6'h09
`define CDX_OPC_DEC 6'h03
`define CDX_OPC_DECSZ 6'h0b
`define CDX_DEST_BIT 5
`define CDX_ADDR_HI 4
`define CDX_ADDR_LO 0
`define CDX_DEST_ACC 1'h0
`define CDX_DEST_FILE 1'h1
`define CDX_ACC_RST 8'h00
`define CDX_ZF_RST 1'h0
`endif

// >>> rtl/cdx_pkg.sv
// Types for the complement and decrement file-op unit.
// Assumes the constants header sits beside it.
package cdx_pkg;
  typedef enum logic [1:0] {
    CDX_OP_NONE,
    CDX_OP_COMPL,
    CDX_OP_DEC,
    CDX_OP_DECSZ
  } cdx_op_t;
endpackage

// >>> rtl/cdx_decode.sv
// Opcode classifier for the three file-register operations.
// Assumes a 12-bit instruction word from the fetch stage.
`timescale 1ns/1ps
`include "cdx_params.svh"
module cdx_decode (
  input wire logic [11:0] instr,
  output cdx_pkg::cdx_op_t op,
  output logic dest_file,
  output logic [4:0] file_addr
);
  always_comb begin
    if (instr[`CDX_OPC_HI:`CDX_OPC_LO] == `CDX_OPC_COMPL) begin
      op = cdx_pkg::CDX_OP_COMPL;
    end else if (instr[`CDX_OPC_HI:`CDX_OPC_LO] == `CDX_OPC_DEC) begin
      op = cdx_pkg::CDX_OP_DEC;
    end else if (instr[`CDX_OPC_HI:`CDX_OPC_LO] == `CDX_OPC_DECSZ) begin
      op = cdx_pkg::CDX_OP_DECSZ;
    end else begin
      op = cdx_pkg::CDX_OP_NONE;
    end
    dest_file = instr[`CDX_DEST_BIT];
    file_addr = instr[`CDX_ADDR_HI:`CDX_ADDR_LO];
  end
endmodule

// >>> testbench/complement_decrement_exec_tb_top.sv
// Self-checking bench for the file-op execute stage.
// Assumes the bench answers file_raddr with file_rdata at once.
`timescale 1ns/1ps
module complement_decrement_exec_tb_top;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic instr_valid = 1'h0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [4:0] file_raddr;
  logic [4:0] file_waddr;
  logic [7:0] file_wdata;
  logic [7:0] acc;
  logic file_we;
  logic zero_flag;
  logic squash_next;
  logic op_hit;
  int errors = 0;
  int check_count = 0;

  cdx_exec i_cdx_exec (.core_clk(core_clk), .srst(srst),
    .instr_valid(instr_valid), .instr(instr), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag),
    .squash_next(squash_next), .op_hit(op_hit));

  initial begin
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t value %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %b exp %b", $time, got, exp);
    end
  endtask

  // Presents one word at the falling edge; returns just after it is taken.
  task automatic issue(input logic [5:0] opc, input logic d,
                       input logic [4:0] f, input logic [7:0] rd);
    @(negedge core_clk);
    instr_valid = 1'h1;
    instr = {opc, d, f};
    file_rdata = rd;
    @(posedge core_clk);
    #1;
    chk_v({3'h0, file_raddr}, {3'h0, f});
  endtask

  task automatic t_compl;
    issue(6'h09, 1'h1, 5'h03, 8'h13);
    chk_b(file_we, 1'h1);
    chk_v({3'h0, file_waddr}, 8'h03);
    chk_v(file_wdata, 8'hec);
    chk_b(zero_flag, 1'h0);
    issue(6'h09, 1'h0, 5'h07, 8'hff);
    chk_v(acc, 8'h00);
    chk_b(zero_flag, 1'h1);
    chk_b(file_we, 1'h0);
    issue(6'h09, 1'h0, 5'h07, 8'h13);
    chk_v(acc, 8'hec);
    chk_b(zero_flag, 1'h0);
    $display("test complement done");
  endtask

  task automatic t_dec;
    issue(6'h03, 1'h1, 5'h1f, 8'h00);
    chk_v(file_wdata, 8'hff);
    chk_v({3'h0, file_waddr}, 8'h1f);
    chk_b(zero_flag, 1'h0);
    issue(6'h03, 1'h0, 5'h00, 8'h01);
    chk_v(acc, 8'h00);
    chk_b(zero_flag, 1'h1);
    $display("test decrement done");
  endtask

  task automatic t_decsz;
    issue(6'h0b, 1'h0, 5'h01, 8'h01);
    chk_b(squash_next, 1'h1);
    chk_b(op_hit, 1'h1);
    issue(6'h09, 1'h1, 5'h02, 8'h55);
    chk_b(op_hit, 1'h0);
    chk_b(file_we, 1'h0);
    chk_b(zero_flag, 1'h1);
    issue(6'h03, 1'h1, 5'h04, 8'h06);
    chk_b(zero_flag, 1'h0);
    issue(6'h0b, 1'h1, 5'h04, 8'h01);
    chk_v(file_wdata, 8'h00);
    chk_b(zero_flag, 1'h0);
    chk_b(squash_next, 1'h1);
    issue(6'h03, 1'h0, 5'h06, 8'h09);
    chk_b(op_hit, 1'h0);
    chk_v(acc, 8'h00);
    issue(6'h0b, 1'h0, 5'h05, 8'h03);
    chk_v(acc, 8'h02);
    chk_b(squash_next, 1'h0);
    $display("test decsz done");
  endtask

  // Mid-run reset with a live accumulator and a set zero flag.
  task automatic t_reset;
    issue(6'h03, 1'h0, 5'h08, 8'h01);
    chk_b(zero_flag, 1'h1);
    issue(6'h0b, 1'h0, 5'h09, 8'h10);
    chk_v(acc, 8'h0f);
    chk_b(zero_flag, 1'h1);
    chk_b(squash_next, 1'h0);
    @(negedge core_clk);
    srst = 1'h1;
    instr_valid = 1'h0;
    @(posedge core_clk);
    #1;
    chk_v(acc, 8'h00);
    chk_b(zero_flag, 1'h0);
    chk_b(op_hit, 1'h0);
    chk_b(file_we, 1'h0);
    chk_b(squash_next, 1'h0);
    @(negedge core_clk);
    srst = 1'h0;
    issue(6'h09, 1'h0, 5'h0a, 8'h13);
    chk_v(acc, 8'hec);
    chk_b(op_hit, 1'h1);
    $display("test reset done");
  endtask

  task automatic t_other;
    issue(6'h0a, 1'h1, 5'h05, 8'h10);
    chk_b(op_hit, 1'h0);
    chk_b(file_we, 1'h0);
    @(negedge core_clk);
    instr_valid = 1'h0;
    instr = {6'h09, 1'h1, 5'h06};
    @(posedge core_clk);
    #1;
    chk_b(op_hit, 1'h0);
    chk_b(file_we, 1'h0);
    chk_v(acc, 8'hec);
    $display("test other done");
  endtask

  initial begin
    #5000;
    errors++;
    $display("ERROR %0t watchdog", $time);
    print_verdict();
  end

  initial begin
    repeat (8) @(negedge core_clk);
    srst = 1'h0;
    chk_v(acc, 8'h00);
    t_compl();
    t_dec();
    t_decsz();
    t_reset();
    t_other();
    print_verdict();
  end
endmodule
